// *** hdl/uart_status_irq_control.sv ***
// Serial port status, error flags and interrupt control with a Wishbone slave.
// ----------------------------------------------------------------------
// How it works
// - Error flags interrupt when error enable set.
// - Error shares receive or combined interrupt.
// - Enable low blocks errors; receive done interrupts.
// - Detected break requests reset when enabled.
// - Overrun: bit 8 arrives while receive done.
// - Break flag after 11 low bit times.
// - Framing flag on low stop bit.
// - Last-character select adds final stop interrupt.
// - Without select, one interrupt per character.
// - Write to empty buffer with idle shifter interrupts at once.
// - Split bit separates receive and transmit interrupts.
// - Split bit resets to zero.
// - Position select: stop begin or end.
// - End placement single buffered may leave gap.
// - Double buffer bit enables buffering, resets zero.
// - Mode bits 00 decode shift-register mode.
// - Mode 1 break spans start, data, stops.
// ----------------------------------------------------------------------
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "uart_status_cfg.svh"
module uart_status_irq_control
    import uart_status_pkg::*;
(
    // Clock, enable and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [`WB_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [`WB_DAT_W-1:0]  wb_dat_i,
    output logic      [`WB_DAT_W-1:0]  wb_dat_o,
    output logic                       wb_ack_o,
    // Receiver side
    input  wire logic                  rx_line,
    input  wire logic                  bit_tick,
    input  wire rx_evt_s               rx_evt,
    input  wire logic                  rx_done_flag,
    // Transmitter side
    input  wire logic                  tx_done_flag,
    input  wire tx_evt_s               tx_evt,
    output logic                       tx_load,
    output logic                       tx_done_set,
    // Mode bits
    input  wire logic                  mode_select_high,
    input  wire logic                  mode_select_low,
    // Interrupts and reset request
    output logic                       serial_irq,
    output logic                       serial_tx_irq,
    output logic                       device_reset_req
);

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    top_state_s q;
    top_state_s d;
    err_evt_s   err_evt;
    logic       mode0;
    logic       dbl_eff;
    logic       at_end_eff;
    logic       req;
    logic       hit_status;
    logic       hit_brk;
    logic       wr_status;
    logic       wr_brk;
    logic       err_irq;
    status_s    wval;

    // Mode 0 is the shift-register mode; buffering and end placement are held off there.
    assign mode0      = ~mode_select_high & ~mode_select_low;
    assign dbl_eff    = q.st.dbl & ~mode0;
    assign at_end_eff = q.st.at_end & ~mode0;

    assign req        = wb_cyc_i & wb_stb_i & ~q.ack;
    assign hit_status = (wb_adr_i[`WB_ADR_W-1:2] == `STATUS_IDX);
    assign hit_brk    = (wb_adr_i[`WB_ADR_W-1:2] == `BRK_CTRL_IDX);
    // Writes land at the edge where the master samples ack, its request still held.
    assign wr_status  = wb_cyc_i & wb_stb_i & q.ack & wb_we_i & wb_sel_i[0] & hit_status;
    assign wr_brk     = wb_cyc_i & wb_stb_i & q.ack & wb_we_i & wb_sel_i[0] & hit_brk;
    assign wval       = status_s'(wb_dat_i[7:0]);

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    err_detect u_err (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .ce           (ce),
        .rx_line      (rx_line),
        .bit_tick     (bit_tick),
        .rx           (rx_evt),
        .rx_done_flag (rx_done_flag),
        .evt          (err_evt)
    );

    tx_irq_ctrl u_tx (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .dbl      (dbl_eff),
        .last_sel (q.st.last_sel & dbl_eff),
        .at_end   (at_end_eff),
        .tx       (tx_evt),
        .load     (tx_load),
        .irq      (tx_done_set)
    );

    // ------------------------------------------------------------------
    // Register file and interrupt routing
    // ------------------------------------------------------------------
    always_comb begin
        d     = q;
        d.ack = req;
        if (req && !wb_we_i) begin
            if (hit_status) begin
                d.rdat = q.st;
            end else if (hit_brk) begin
                d.rdat = {7'h00, q.brr_en};
            end else begin
                d.rdat = 8'h00;
            end
        end
        if (wr_status) begin
            d.st.dbl      = wval.dbl;
            d.st.at_end   = wval.at_end;
            d.st.split    = wval.split;
            d.st.last_sel = wval.last_sel;
            d.st.error_irq_enable = wval.error_irq_enable;
            // Flags only clear on a written zero; a one leaves them as they are.
            d.st.framing_error_flag = q.st.framing_error_flag & wval.framing_error_flag;
            d.st.long_low_line_flag = q.st.long_low_line_flag & wval.long_low_line_flag;
            d.st.oe       = q.st.oe & wval.oe;
        end
        if (wr_brk) begin
            d.brr_en = wb_dat_i[`BIT_BRR_EN];
        end
        // A new event wins over a clear in the same cycle.
        if (err_evt.overrun) begin
            d.st.oe = 1'b1;
        end
        if (err_evt.brk) begin
            d.st.long_low_line_flag = 1'b1;
        end
        if (err_evt.framing) begin
            d.st.framing_error_flag = 1'b1;
        end
        d.rst_req = err_evt.brk & q.brr_en;
        // Serial interrupt at vector 0023h; errors join it only when enabled.
        err_irq = q.st.error_irq_enable
                & (q.st.framing_error_flag | q.st.long_low_line_flag | q.st.oe);
        if (q.st.split) begin
            d.irq    = rx_done_flag | err_irq;
            d.tx_irq = tx_done_flag;
        end else begin
            d.irq    = rx_done_flag | tx_done_flag | err_irq;
            d.tx_irq = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.st     <= `STATUS_RST;
            q.brr_en <= `BRR_EN_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_dat_o         = {24'h000000, q.rdat};
    assign wb_ack_o         = q.ack;
    assign serial_irq       = q.irq;
    assign serial_tx_irq    = q.tx_irq;
    assign device_reset_req = q.rst_req;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    error_irq_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && q.st.error_irq_enable
            && (q.st.framing_error_flag || q.st.long_low_line_flag || q.st.oe)) |=> serial_irq)
        else $error("enabled error flag did not interrupt");
    error_irq_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && !q.st.error_irq_enable && !rx_done_flag && !tx_done_flag) |=> !serial_irq)
        else $error("disabled error flag interrupted");
    rx_always_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && rx_done_flag) |=> serial_irq)
        else $error("receive done did not interrupt");
    split_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && q.st.split && !rx_done_flag && !q.st.error_irq_enable) |=>
            (!serial_irq && serial_tx_irq == $past(tx_done_flag)))
        else $error("split interrupts not separated");
    combined_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && !q.st.split && tx_done_flag) |=> (serial_irq && !serial_tx_irq))
        else $error("combined interrupt missing transmit done");
    break_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && err_evt.brk) |=> (device_reset_req == $past(q.brr_en)))
        else $error("break reset request wrong");
    flag_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && q.st.oe && !wr_status) |=> q.st.oe)
        else $error("overrun flag lost without a clear");
    set_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && wr_status && !wval.long_low_line_flag && err_evt.brk) |=> q.st.long_low_line_flag)
        else $error("break event lost against a clear");
    bus_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req) |=> (wb_ack_o ##1 !wb_ack_o))
        else $error("bus ack not a single cycle");

    break_c: cover property (@(posedge mclk) disable iff (!rst_n)
        err_evt.brk && q.brr_en);
    split_c: cover property (@(posedge mclk) disable iff (!rst_n)
        q.st.split && serial_tx_irq);
    overrun_c: cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(q.st.oe) ##[1:50] !q.st.oe);

endmodule

// *** hdl/uart_status_cfg.svh ***
// Register indices, bit positions, reset values and counts of the serial status block.
`ifndef UART_STATUS_CFG_SVH
`define UART_STATUS_CFG_SVH

// ----------------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------------
`define WB_ADR_W        12
`define STATUS_IDX      10'h0ba
`define BRK_CTRL_IDX    10'h0bc
`define WB_DAT_W        32

// ----------------------------------------------------------------------
// Status and break control register bit positions
// ----------------------------------------------------------------------
`define BIT_ERR_IRQ_EN  0
`define BIT_OE          1
`define BIT_LONG_LOW    2
`define BIT_FRAMING     3
`define BIT_LAST_SEL    4
`define BIT_SPLIT       5
`define BIT_AT_END      6
`define BIT_DBL         7
`define BIT_BRR_EN      0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define STATUS_RST      8'h00
`define BRR_EN_RST      1'b0
`define BREAK_BITS      4'hb

`endif

// *** hdl/uart_status_pkg.sv ***
// Types shared by the serial status and interrupt control block.
package uart_status_pkg;

    // ------------------------------------------------------------------
    // Register layout and event carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic dbl;
        logic at_end;
        logic split;
        logic last_sel;
        logic framing_error_flag;
        logic long_low_line_flag;
        logic oe;
        logic error_irq_enable;
    } status_s;

    typedef struct packed {
        logic bit8_strobe;
        logic stop_strobe;
        logic stop_level;
    } rx_evt_s;

    typedef struct packed {
        logic data_wr;
        logic stop_begin;
        logic stop_end;
        logic busy;
    } tx_evt_s;

    typedef struct packed {
        logic overrun;
        logic brk;
        logic framing;
    } err_evt_s;

    typedef logic [3:0] low_cnt_t;

    // ------------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_EMPTY = 2'b01,
        TX_FULL  = 2'b10
    } tx_buf_e;

    typedef struct packed {
        tx_buf_e buf_st;
        logic    load;
        logic    irq;
    } tx_state_s;

    typedef struct packed {
        low_cnt_t low_bits;
        err_evt_s evt;
    } err_state_s;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdat;
        status_s    st;
        logic       brr_en;
        logic       irq;
        logic       tx_irq;
        logic       rst_req;
    } top_state_s;

endpackage

// *** hdl/err_detect.sv ***
// Receive error event detector: overrun, long low line and framing.
`timescale 1ns/1ps
`include "uart_status_cfg.svh"
module err_detect
    import uart_status_pkg::*;
(
    // Clock and reset
    input  wire logic     mclk,
    input  wire logic     rst_n,
    input  wire logic     ce,
    // Receiver side
    input  wire logic     rx_line,
    input  wire logic     bit_tick,
    input  wire rx_evt_s  rx,
    input  wire logic     rx_done_flag,
    // Events
    output err_evt_s      evt
);

    err_state_s q;
    err_state_s d;

    always_comb begin
        d = q;
        d.evt = '0;
        d.evt.overrun = rx.bit8_strobe & rx_done_flag;
        d.evt.framing = rx.stop_strobe & ~rx.stop_level;
        if (rx_line) begin
            d.low_bits = '0;
        end else if (bit_tick && q.low_bits != `BREAK_BITS) begin
            // Start bit, data bits and stop times all count as low bit times.
            d.low_bits = q.low_bits + 4'h1;
            d.evt.brk  = (q.low_bits == `BREAK_BITS - 4'h1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign evt = q.evt;

    break_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && !rx_line && bit_tick && q.low_bits == 4'ha) |=> q.evt.brk)
        else $error("long low line not flagged after eleven bit times");
    overrun_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && rx.bit8_strobe && rx_done_flag) |=> q.evt.overrun)
        else $error("overrun event missed");
    framing_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && rx.stop_strobe) |=> (q.evt.framing == !$past(rx.stop_level)))
        else $error("framing event does not follow stop level");

endmodule

// *** hdl/tx_irq_ctrl.sv ***
// Transmit interrupt placement and transmit double buffer control.
`timescale 1ns/1ps
`include "uart_status_cfg.svh"
module tx_irq_ctrl
    import uart_status_pkg::*;
(
    // Clock and reset
    input  wire logic    mclk,
    input  wire logic    rst_n,
    input  wire logic    ce,
    // Control
    input  wire logic    dbl,
    input  wire logic    last_sel,
    input  wire logic    at_end,
    // Transmitter side
    input  wire tx_evt_s tx,
    output logic         load,
    output logic         irq
);

    tx_state_s q;
    tx_state_s d;
    logic      stop_pt;

    // Transmit interrupt point within the stop bit.
    assign stop_pt = at_end ? tx.stop_end : tx.stop_begin;

    always_comb begin
        d      = q;
        d.load = 1'b0;
        d.irq  = 1'b0;
        if (!dbl) begin
            // Single buffering: a write loads the shifter, the stop point signals.
            d.buf_st = TX_EMPTY;
            d.load   = tx.data_wr;
            d.irq    = stop_pt;
        end else begin
            unique case (q.buf_st)
                TX_EMPTY: begin
                    if (tx.data_wr && !tx.busy) begin
                        d.load = 1'b1;
                        d.irq  = 1'b1;
                    end else if (tx.data_wr) begin
                        d.buf_st = TX_FULL;
                    end else if (stop_pt) begin
                        d.irq = last_sel;
                    end
                end
                TX_FULL: begin
                    if (stop_pt) begin
                        d.irq = 1'b1;
                    end
                    if (tx.stop_end) begin
                        d.load   = 1'b1;
                        d.buf_st = TX_EMPTY;
                    end
                end
                default: begin
                    d.buf_st = TX_EMPTY;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{buf_st: TX_EMPTY, load: 1'b0, irq: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign load = q.load;
    assign irq  = q.irq;

    first_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && dbl && q.buf_st == TX_EMPTY && tx.data_wr && !tx.busy) |=> (irq && load))
        else $error("write to empty buffer gave no immediate interrupt");
    no_last_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && dbl && !last_sel && q.buf_st == TX_EMPTY && !tx.data_wr) |=> !irq)
        else $error("extra transmit interrupt without last-character select");
    last_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && dbl && last_sel && q.buf_st == TX_EMPTY && !tx.data_wr && stop_pt) |=> irq)
        else $error("last-character interrupt missing");
    stop_place_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && !dbl && at_end && !tx.stop_end) |=> !irq)
        else $error("transmit interrupt not at end of stop bit");

    buffered_c: cover property (@(posedge mclk) disable iff (!rst_n)
        q.buf_st == TX_FULL ##[1:100] q.load);

endmodule

// *** test/remote_serial_model.sv ***
// Remote serial partner: receive events, long low line and shifter stop timing.
`timescale 1ns/1ps
module remote_serial_model
    import uart_status_pkg::*;
(
    // Clock
    input  wire logic mclk,
    // Line side
    output logic      rx_line,
    output logic      bit_tick,
    output rx_evt_s   rx_evt,
    output tx_evt_s   tx_evt
);
    initial begin
        rx_line  = 1'b1;
        bit_tick = 1'b0;
        rx_evt   = '0;
        tx_evt   = '0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Received character: bit 8 strobe, then the sampled stop level.
    task automatic rx_frame(input logic lvl);
        step(1);
        rx_evt.bit8_strobe <= 1'b1;
        step(1);
        rx_evt.bit8_strobe <= 1'b0;
        rx_evt.stop_strobe <= 1'b1;
        rx_evt.stop_level  <= lvl;
        step(1);
        rx_evt.stop_strobe <= 1'b0;
        rx_evt.stop_level  <= ~lvl;
    endtask
    // Line held low for n bit times; eleven make a break.
    task automatic line_low(input int n);
        rx_line <= 1'b0;
        for (int i = 0; i < n; i++) begin
            step(3);
            bit_tick <= 1'b1;
            step(1);
            bit_tick <= 1'b0;
        end
        step(2);
        rx_line <= 1'b1;
    endtask
    task automatic tx_start;
        step(1);
        tx_evt.busy <= 1'b1;
    endtask
    task automatic sb;
        step(3);
        tx_evt.stop_begin <= 1'b1;
        step(1);
        tx_evt.stop_begin <= 1'b0;
    endtask
    task automatic se(input logic keep);
        step(3);
        tx_evt.stop_end <= 1'b1;
        step(1);
        tx_evt.stop_end <= 1'b0;
        tx_evt.busy     <= keep;
    endtask
endmodule

// *** test/uart_status_irq_control_tb.sv ***
// Self-checking bench of the serial status and interrupt control block.
`timescale 1ns/1ps
`include "uart_status_cfg.svh"
module uart_status_irq_control_tb
    import uart_status_pkg::*;
;
    localparam logic [11:0] ST_A = {`STATUS_IDX, 2'b00};
    localparam logic [11:0] BK_A = {`BRK_CTRL_IDX, 2'b00};
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = '0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic        ack;
    logic        rx_done = 1'b0;
    logic        tx_done = 1'b0;
    logic        dwr = 1'b0;
    logic        msl = 1'b1;
    logic        msh = 1'b0;
    logic        ce_in = 1'b1;
    logic [3:0]  bsel = 4'h1;
    logic        tx_load;
    logic        tx_set;
    logic        sirq;
    logic        stxirq;
    logic        rst_req;
    logic        m_line;
    logic        m_tick;
    rx_evt_s     m_rx;
    tx_evt_s     m_tx;
    tx_evt_s     tx_all;
    int          fails = 0;
    int          checks = 0;
    integer      seed = 32'h0a11374f;
    logic [31:0] rq[$];
    logic [1:0]  eq[$];
    always #12.5 mclk = ~mclk;
    assign tx_all = tx_evt_s'(m_tx | {dwr, 3'b000});
    remote_serial_model partner (.mclk(mclk), .rx_line(m_line), .bit_tick(m_tick),
        .rx_evt(m_rx), .tx_evt(m_tx));
    uart_status_irq_control dut (.mclk(mclk), .rst_n(rst_n), .ce(ce_in),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_line(m_line),
        .bit_tick(m_tick), .rx_evt(m_rx), .rx_done_flag(rx_done), .tx_done_flag(tx_done),
        .tx_evt(tx_all), .tx_load(tx_load), .tx_done_set(tx_set),
        .mode_select_high(msh), .mode_select_low(msl), .serial_irq(sirq),
        .serial_tx_irq(stxirq), .device_reset_req(rst_req));
    // ----------------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= bsel;
        wdat <= d;
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic pulse_wr;
        @(posedge mclk);
        dwr <= 1'b1;
        @(posedge mclk);
        dwr <= 1'b0;
    endtask
    task automatic ev(input logic [1:0] c);
        if (eq.size() == 0) chk("event", 2'd0, c);
        else chk("event", eq.pop_front(), c);
    endtask
    // ----------------------------------------------------------------------
    // Result watchers
    // ----------------------------------------------------------------------
    always @(negedge mclk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (rq.size() == 0) chk("read", 32'h0, 32'h1);
            else chk("read data", rq.pop_front(), rdat);
        end
        if (tx_load === 1'b1) ev(2'd1);
        if (tx_set === 1'b1) ev(2'd2);
        if (rst_req === 1'b1) ev(2'd3);
    end
    initial begin
        wait_n(5000);
        fails++;
        conclude();
    end
    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    initial begin
        wait_n(2);
        rst_n <= 1'b1;
        rd(ST_A, 32'h0);
        rd(BK_A, 32'h0);
        wb(1'b1, 12'h100, $random(seed));
        rd(12'h100, 32'h0);
        rd(ST_A, 32'h0);
        $display("test reset done");
        rx_done <= 1'b1;
        partner.rx_frame(1'b1);
        rx_done <= 1'b0;
        partner.rx_frame(1'b1);
        wait_n(4);
        chk("irq blocked", 32'h0, sirq);
        rd(ST_A, 32'h02);
        bsel = 4'he;
        wb(1'b1, ST_A, 32'h01);
        bsel = 4'h1;
        rd(ST_A, 32'h02);
        wb(1'b1, ST_A, 32'h03);
        wait_n(4);
        chk("irq error", 32'h1, sirq);
        wb(1'b1, ST_A, 32'h23);
        wait_n(4);
        chk("irq error split", 32'h1, sirq);
        chk("tx irq quiet", 32'h0, stxirq);
        wb(1'b1, ST_A, 32'h01);
        rd(ST_A, 32'h01);
        wait_n(3);
        chk("irq cleared", 32'h0, sirq);
        wb(1'b1, ST_A, 32'h00);
        rx_done <= 1'b1;
        wait_n(3);
        chk("irq rx done", 32'h1, sirq);
        rx_done <= 1'b0;
        partner.rx_frame(1'b0);
        wait_n(4);
        rd(ST_A, 32'h08);
        wb(1'b1, ST_A, 32'h00);
        rd(ST_A, 32'h00);
        $display("test errors done");
        wb(1'b1, BK_A, 32'h1);
        partner.line_low(10);
        rd(ST_A, 32'h0);
        eq.push_back(2'd3);
        partner.line_low(11);
        wait_n(4);
        rd(ST_A, 32'h04);
        wb(1'b1, ST_A, 32'h00);
        wb(1'b1, BK_A, 32'h0);
        $display("test break done");
        wb(1'b1, ST_A, 32'h20);
        tx_done <= 1'b1;
        wait_n(3);
        chk("split tx irq", 32'h1, stxirq);
        chk("split rx irq", 32'h0, sirq);
        wb(1'b1, ST_A, 32'h00);
        wait_n(3);
        chk("combined irq", 32'h1, sirq);
        chk("combined tx irq", 32'h0, stxirq);
        tx_done <= 1'b0;
        wait_n(3);
        ce_in <= 1'b0;
        rx_done <= 1'b1;
        wait_n(3);
        chk("frozen irq", 32'h0, sirq);
        ce_in <= 1'b1;
        wait_n(3);
        chk("irq after freeze", 32'h1, sirq);
        rx_done <= 1'b0;
        wait_n(3);
        $display("test split done");
        for (int i = 0; i < 3; i++) begin
            msh <= (i == 2);
            msl <= (i == 1);
            wb(1'b1, ST_A, (i == 2) ? 32'h40 : 32'h00);
            eq.push_back(2'd1);
            pulse_wr();
            partner.tx_start();
            if (i != 2) eq.push_back(2'd2);
            partner.sb();
            if (i == 2) eq.push_back(2'd2);
            partner.se(1'b0);
            wait_n(3);
        end
        $display("test single buffer done");
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, ST_A, i ? 32'h90 : 32'h80);
            eq.push_back(2'd1);
            eq.push_back(2'd2);
            pulse_wr();
            partner.tx_start();
            pulse_wr();
            pulse_wr();
            eq.push_back(2'd2);
            partner.sb();
            eq.push_back(2'd1);
            partner.se(1'b1);
            if (i != 0) eq.push_back(2'd2);
            partner.sb();
            partner.se(1'b0);
            wait_n(3);
        end
        $display("test double buffer done");
        wait_n(5);
        chk("events left", 32'h0, eq.size());
        chk("reads left", 32'h0, rq.size());
        conclude();
    end
endmodule
